// *** include/qdrmc_regs.vh ***
// Register map, field positions and sizes of the read-side memory controller.
// Assumes an 8-bit register port in the 30Bxx domain and one core clock.
`ifndef QDRMC_REGS_VH
`define QDRMC_REGS_VH

// Register addresses
`define QDRMC_ADDR_W          20
`define QDRMC_CLOCK_CONFIG    20'h30b03
`define QDRMC_PLL_FACTORS     20'h30b04
`define QDRMC_ALARM_STATUS    20'h30b05
`define QDRMC_EMPTY_LEVEL     20'h30b06
`define QDRMC_DOMAIN_HI       12'h30b

// Reset values
`define QDRMC_CLOCK_CONFIG_RST 8'h00
`define QDRMC_PLL_FACTORS_RST  8'h00
`define QDRMC_EMPTY_LEVEL_RST  4'h0

// Clock configuration fields (bit 0 is the least significant bit)
`define QDRMC_BURST_BIT       7
`define QDRMC_ICK_HI          5
`define QDRMC_ICK_LO          4
`define QDRMC_OCK_BIT         0
// PLL factor fields
`define QDRMC_PLL_N_HI        6
`define QDRMC_PLL_N_LO        4
`define QDRMC_PLL_M_HI        2
`define QDRMC_PLL_M_LO        0

// Read instruction fields
`define QDRMC_INSTR_W         32
`define QDRMC_IADDR_HI        17
`define QDRMC_IADDR_LO        0
`define QDRMC_ILEN_HI         25
`define QDRMC_ILEN_LO         18
`define QDRMC_MADDR_W         18
`define QDRMC_LEN_W           8

// Buffer sizes
`define QDRMC_IQ_DEPTH        4
`define QDRMC_IQ_AW           2
`define QDRMC_DATA_W          72
`define QDRMC_WORD_W          36
`define QDRMC_DQ_DEPTH        64
`define QDRMC_DQ_AW           6
`define QDRMC_IQ_FULL_LEVEL   3'h3

// Alarm bit positions
`define QDRMC_AL_LEN          0
`define QDRMC_AL_ID           1
`define QDRMC_AL_WOVR         2
`define QDRMC_AL_WUND         3
`define QDRMC_AL_ROVR         4
`define QDRMC_AL_RUND         5
`define QDRMC_AL_W            6

`endif

// *** src/qdrmc_read_ctrl.v ***
// Read side, clocking configuration and alarms of the QDR SRAM controller,
// with the generic FIFO used for the instruction queue and data buffer.
// Assumes clk_sys is the core clock and fabric logic shares it.
`timescale 1ns/10ps
`include "qdrmc_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// Generic FIFO with Gray-coded pointers
module qdrmc_fifo #(
  parameter W  = 72,
  parameter D  = 64,
  parameter AW = 6
) (
  input  wire          clk_sys,
  input  wire          rst_n,
  input  wire          ce,
  input  wire          in_valid,
  output wire          in_ready,
  input  wire [W-1:0]  in_data,
  output wire          out_valid,
  input  wire          out_ready,
  output wire [W-1:0]  out_data,
  output wire [AW:0]   level
);
  reg  [W-1:0] mem [0:D-1];
  reg  [AW:0]  wr_bin;
  reg  [AW:0]  rd_bin;
  reg  [AW:0]  wr_gray;
  reg  [AW:0]  rd_gray;
  wire         do_push;
  wire         do_pop;
  wire [AW:0]  next_wr_bin;
  wire [AW:0]  next_rd_bin;

  function [AW:0] to_gray;
    input [AW:0] b;
    begin
      to_gray = b ^ (b >> 1);
    end
  endfunction

  // Flags compare Gray pointers, full when top two bits differ
  assign in_ready  = ~(wr_gray == {~rd_gray[AW:AW-1], rd_gray[AW-2:0]});
  assign out_valid = ~(wr_gray == rd_gray);
  assign do_push   = in_valid & in_ready;
  assign do_pop    = out_valid & out_ready;
  assign next_wr_bin = wr_bin + {{AW{1'b0}}, 1'b1};
  assign next_rd_bin = rd_bin + {{AW{1'b0}}, 1'b1};
  assign out_data  = mem[rd_bin[AW-1:0]];
  assign level     = wr_bin - rd_bin;

  // Pointer update
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_bin  <= {(AW+1){1'b0}};
      rd_bin  <= {(AW+1){1'b0}};
      wr_gray <= {(AW+1){1'b0}};
      rd_gray <= {(AW+1){1'b0}};
    end else if (ce) begin
      if (do_push) begin
        wr_bin  <= next_wr_bin;
        wr_gray <= to_gray(next_wr_bin);
      end
      if (do_pop) begin
        rd_bin  <= next_rd_bin;
        rd_gray <= to_gray(next_rd_bin);
      end
    end
  end

  // Storage write
  always @(posedge clk_sys) begin
    if (ce && do_push) begin
      mem[wr_bin[AW-1:0]] <= in_data;
    end
  end
endmodule // qdrmc_fifo

////////////////////////////////////////////////////////////////////////////////
// Top: read controller, clock configuration and alarms
module qdrmc_read_ctrl (
  input  wire                         clk_sys,   // Core and both fabric clocks
  input  wire                         rst_n,
  input  wire                         ce,
  // Register port
  input  wire [`QDRMC_ADDR_W-1:0]     reg_addr,
  input  wire                         reg_wr,
  input  wire                         reg_rd,
  input  wire [7:0]                   reg_wdata,
  output reg  [7:0]                   reg_rdata,
  // Fabric instruction side
  input  wire                         fabric_instr_wr,
  input  wire [`QDRMC_INSTR_W-1:0]    fabric_instr_data,
  output reg                          rd_instr_queue_full,
  // Fabric data side
  input  wire                         fabric_rd_pop,
  output reg  [`QDRMC_DATA_W-1:0]     rd_data_out,
  output reg                          rd_data_valid,
  output reg                          rd_data_empty,
  // Write path events
  input  wire                         wr_len_mismatch_evt,
  input  wire                         wr_id_mismatch_evt,
  input  wire                         wr_buf_overrun_evt,
  input  wire                         wr_buf_underrun_evt,
  // SRAM side
  output reg  [`QDRMC_MADDR_W-1:0]    mem_addr,
  output reg                          mem_rd_n,
  output reg                          mem_clk_k,
  input  wire [`QDRMC_WORD_W-1:0]     mem_q,
  input  wire                         mem_q_valid,
  // Clock generator control
  output reg  [1:0]                   input_clk_source_sel,
  output reg                          output_clk_derive_sel,
  output reg  [2:0]                   pll_n,
  output reg  [2:0]                   pll_m
);
  localparam S_IDLE  = 2'b00;
  localparam S_LOAD  = 2'b01;
  localparam S_ISSUE = 2'b10;

  reg  [7:0]                 clock_config;
  reg  [7:0]                 pll_factors;
  reg  [3:0]                 empty_level;
  reg  [`QDRMC_AL_W-1:0]     alarms;
  reg  [1:0]                 state;
  reg  [`QDRMC_MADDR_W-1:0]  seq_addr;
  reg  [`QDRMC_LEN_W-1:0]    seq_left;
  reg  [`QDRMC_DQ_AW:0]      pending;
  reg  [`QDRMC_WORD_W-1:0]   q_meta;
  reg  [`QDRMC_WORD_W-1:0]   q_sync;
  reg                        qv_meta;
  reg                        qv_sync;
  reg  [`QDRMC_WORD_W-1:0]   first_word;
  reg                        half;
  reg                        dq_push;
  reg  [`QDRMC_DATA_W-1:0]   dq_word;
  wire                       iq_ready;
  wire                       iq_valid;
  wire [`QDRMC_INSTR_W-1:0]  iq_data;
  wire [`QDRMC_IQ_AW:0]      iq_level;
  wire                       dq_ready;
  wire                       dq_valid;
  wire [`QDRMC_DATA_W-1:0]   dq_data;
  wire [`QDRMC_DQ_AW:0]      dq_level;
  wire                       iq_pop;
  wire                       issue;
  wire                       burst4;
  wire [`QDRMC_LEN_W-1:0]    step;
  wire                       reg_hit;
  wire                       line_in;
  wire                       pop_ok;
  wire [`QDRMC_DQ_AW+1:0]    room_need;
  wire [`QDRMC_AL_W-1:0]     alarm_set;

  // Instruction queue, four deep
  qdrmc_fifo #(
    .W  (`QDRMC_INSTR_W),
    .D  (`QDRMC_IQ_DEPTH),
    .AW (`QDRMC_IQ_AW)
  ) u_read_instruction_queue (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .ce        (ce),
    .in_valid  (fabric_instr_wr),
    .in_ready  (iq_ready),
    .in_data   (fabric_instr_data),
    .out_valid (iq_valid),
    .out_ready (iq_pop),
    .out_data  (iq_data),
    .level     (iq_level)
  );

  // Read data buffer, 64 by 72
  qdrmc_fifo #(
    .W  (`QDRMC_DATA_W),
    .D  (`QDRMC_DQ_DEPTH),
    .AW (`QDRMC_DQ_AW)
  ) u_read_data_buffer (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .ce        (ce),
    .in_valid  (dq_push),
    .in_ready  (dq_ready),
    .in_data   (dq_word),
    .out_valid (dq_valid),
    .out_ready (pop_ok),
    .out_data  (dq_data),
    .level     (dq_level)
  );

  assign reg_hit = (reg_addr[`QDRMC_ADDR_W-1:8] == `QDRMC_DOMAIN_HI);
  assign burst4  = clock_config[`QDRMC_BURST_BIT];
  assign step    = burst4 ? 8'h02 : 8'h01;
  assign iq_pop  = (state == S_IDLE) & iq_valid;
  // Lines in flight plus stored must fit before another read issues
  assign room_need = {1'b0, pending} + {1'b0, dq_level} + {6'h00, step[1:0]};
  assign issue   = (state == S_ISSUE) && (seq_left != 8'h00) &&
                   (room_need <= `QDRMC_DQ_DEPTH);
  assign line_in = dq_push & dq_ready;
  assign pop_ok  = fabric_rd_pop & dq_valid;
  assign alarm_set[`QDRMC_AL_LEN]  = wr_len_mismatch_evt;
  assign alarm_set[`QDRMC_AL_ID]   = wr_id_mismatch_evt;
  assign alarm_set[`QDRMC_AL_WOVR] = wr_buf_overrun_evt;
  assign alarm_set[`QDRMC_AL_WUND] = wr_buf_underrun_evt;
  assign alarm_set[`QDRMC_AL_ROVR] = dq_push & ~dq_ready;
  assign alarm_set[`QDRMC_AL_RUND] = fabric_rd_pop & ~dq_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Registers, alarms and clock controls
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      clock_config          <= `QDRMC_CLOCK_CONFIG_RST;
      pll_factors           <= `QDRMC_PLL_FACTORS_RST;
      empty_level           <= `QDRMC_EMPTY_LEVEL_RST;
      alarms                <= {`QDRMC_AL_W{1'b0}};
      reg_rdata             <= 8'h00;
      input_clk_source_sel  <= 2'h0;
      output_clk_derive_sel <= 1'b0;
      pll_n                 <= 3'h0;
      pll_m                 <= 3'h0;
    end else if (ce) begin
      if (reg_wr && reg_hit) begin
        case (reg_addr)
          `QDRMC_CLOCK_CONFIG: clock_config <= reg_wdata;
          `QDRMC_PLL_FACTORS:  pll_factors  <= reg_wdata;
          `QDRMC_EMPTY_LEVEL:  empty_level  <= reg_wdata[3:0];
          default: ;
        endcase
      end
      // Sticky alarms, write one to clear, a new event wins
      if (reg_wr && (reg_addr == `QDRMC_ALARM_STATUS)) begin
        alarms <= (alarms & ~reg_wdata[`QDRMC_AL_W-1:0]) | alarm_set;
      end else begin
        alarms <= alarms | alarm_set;
      end
      if (reg_rd) begin
        case (reg_addr)
          `QDRMC_CLOCK_CONFIG: reg_rdata <= clock_config;
          `QDRMC_PLL_FACTORS:  reg_rdata <= pll_factors;
          `QDRMC_ALARM_STATUS: reg_rdata <= {2'b00, alarms};
          `QDRMC_EMPTY_LEVEL:  reg_rdata <= {4'h0, empty_level};
          default:             reg_rdata <= 8'h00;
        endcase
      end
      input_clk_source_sel  <= clock_config[`QDRMC_ICK_HI:`QDRMC_ICK_LO];
      output_clk_derive_sel <= clock_config[`QDRMC_OCK_BIT];
      pll_n                 <= pll_factors[`QDRMC_PLL_N_HI:`QDRMC_PLL_N_LO];
      pll_m                 <= pll_factors[`QDRMC_PLL_M_HI:`QDRMC_PLL_M_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read sequencer: pop, split, issue reads in queue order
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state     <= S_IDLE;
      seq_addr  <= {`QDRMC_MADDR_W{1'b0}};
      seq_left  <= 8'h00;
      mem_addr  <= {`QDRMC_MADDR_W{1'b0}};
      mem_rd_n  <= 1'b1;
      mem_clk_k <= 1'b0;
    end else if (ce) begin
      mem_clk_k <= ~mem_clk_k;
      mem_rd_n  <= ~issue;
      case (state)
        S_IDLE: begin
          if (iq_valid) begin
            seq_addr <= iq_data[`QDRMC_IADDR_HI:`QDRMC_IADDR_LO];
            seq_left <= iq_data[`QDRMC_ILEN_HI:`QDRMC_ILEN_LO];
            state    <= S_LOAD;
          end
        end
        S_LOAD: begin
          state <= S_ISSUE;
        end
        S_ISSUE: begin
          if (seq_left == 8'h00) begin
            state <= S_IDLE;
          end else if (issue) begin
            mem_addr <= seq_addr;
            seq_addr <= seq_addr + {{(`QDRMC_MADDR_W-1){1'b0}}, 1'b1};
            seq_left <= (seq_left > step) ? seq_left - step : 8'h00;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Return path: two-flop retime, pair DDR words into lines
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      q_meta     <= {`QDRMC_WORD_W{1'b0}};
      q_sync     <= {`QDRMC_WORD_W{1'b0}};
      qv_meta    <= 1'b0;
      qv_sync    <= 1'b0;
      first_word <= {`QDRMC_WORD_W{1'b0}};
      half       <= 1'b0;
      dq_push    <= 1'b0;
      dq_word    <= {`QDRMC_DATA_W{1'b0}};
      pending    <= {(`QDRMC_DQ_AW+1){1'b0}};
    end else if (ce) begin
      q_meta  <= mem_q;
      q_sync  <= q_meta;
      qv_meta <= mem_q_valid;
      qv_sync <= qv_meta;
      dq_push <= 1'b0;
      if (qv_sync) begin
        if (!half) begin
          first_word <= q_sync;
          half       <= 1'b1;
        end else begin
          dq_word <= {first_word, q_sync};
          dq_push <= 1'b1;
          half    <= 1'b0;
        end
      end
      // Reserved lines: added on issue, released when stored
      pending <= pending + (issue ? step[`QDRMC_DQ_AW:0] : 7'h00)
                 - {6'h00, line_in};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fabric-facing flags and data
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_instr_queue_full <= 1'b0;
      rd_data_empty       <= 1'b1;
      rd_data_out         <= {`QDRMC_DATA_W{1'b0}};
      rd_data_valid       <= 1'b0;
    end else if (ce) begin
      // Full with one slot left so one more write is safe
      rd_instr_queue_full <= (iq_level + {2'b00, fabric_instr_wr & iq_ready}
                              - {2'b00, iq_pop}) >= `QDRMC_IQ_FULL_LEVEL;
      // Empty until stored lines exceed the programmed level
      rd_data_empty <= (dq_level + {6'h00, line_in} - {6'h00, pop_ok})
                       <= {3'b000, empty_level};
      rd_data_valid <= pop_ok;
      if (pop_ok) begin
        rd_data_out <= dq_data;
      end
    end
  end
endmodule // qdrmc_read_ctrl

// *** testbench/qdrmc_read_ctrl_props.sv ***
// Checker on the read controller top ports, bound at the foot of this file.
// Assumes the register header is on the include path and one clock domain.
`timescale 1ns/10ps
`include "qdrmc_regs.vh"

module qdrmc_read_ctrl_props (
  input wire        clk_sys,
  input wire        rst_n,
  input wire        ce,
  input wire [19:0] reg_addr,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_wdata,
  input wire [7:0]  reg_rdata,
  input wire        fabric_instr_wr,
  input wire        rd_instr_queue_full,
  input wire        fabric_rd_pop,
  input wire [71:0] rd_data_out,
  input wire        rd_data_valid,
  input wire        rd_data_empty,
  input wire        mem_rd_n,
  input wire        mem_clk_k,
  input wire        mem_q_valid,
  input wire [1:0]  input_clk_source_sel,
  input wire        output_clk_derive_sel,
  input wire [2:0]  pll_n,
  input wire [2:0]  pll_m
);
  reg [7:0] wdata_d1;
  reg [7:0] wdata_d2;

  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Write data delayed to line up with the control copies
  always @(posedge clk_sys) begin
    wdata_d1 <= reg_wdata;
    wdata_d2 <= wdata_d1;
  end

  ////////////////////////////////////////////////////////////////////////////
  wire cfg_wr = ce && reg_wr && reg_addr == `QDRMC_CLOCK_CONFIG;
  wire pll_wr = ce && reg_wr && reg_addr == `QDRMC_PLL_FACTORS;
  sram_clk_a: assert property (rst_n && ce |=> mem_clk_k != $past(mem_clk_k))
    else $error("sram clock did not toggle");
  src_sel_a: assert property (cfg_wr |-> ##2 input_clk_source_sel == wdata_d2[5:4])
    else $error("input clock select wrong");
  derive_sel_a: assert property (cfg_wr |-> ##2 output_clk_derive_sel == wdata_d2[0])
    else $error("output clock derive select wrong");
  pll_copy_a: assert property (pll_wr |-> ##2 {pll_n, pll_m} == {wdata_d2[6:4], wdata_d2[2:0]})
    else $error("pll factors wrong");
  full_cause_a: assert property ($rose(rd_instr_queue_full) |->
    $past(fabric_instr_wr) || $past(fabric_instr_wr, 2))
    else $error("full rose without a push");
  empty_hold_a: assert property ((!mem_q_valid && !reg_wr) [*8] ##0 rd_data_empty
    |=> rd_data_empty)
    else $error("empty fell without returned data");
  line_hold_a: assert property (!fabric_rd_pop |=> $stable(rd_data_out))
    else $error("read line changed without pop");
  valid_pop_a: assert property (rd_data_valid |-> $past(fabric_rd_pop))
    else $error("valid without pop");
  unmapped_zero_a: assert property (reg_rd && ce && reg_addr[19:8] != `QDRMC_DOMAIN_HI
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");

  // Main scenarios reached
  full_seen_c: cover property ($rose(rd_instr_queue_full));
  data_seen_c: cover property ($fell(rd_data_empty));
  pop_seen_c: cover property (rd_data_valid);
  read_seen_c: cover property (!mem_rd_n);
endmodule // qdrmc_read_ctrl_props

bind qdrmc_read_ctrl qdrmc_read_ctrl_props qdrmc_read_ctrl_props_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .fabric_instr_wr(fabric_instr_wr), .rd_instr_queue_full(rd_instr_queue_full),
  .fabric_rd_pop(fabric_rd_pop), .rd_data_out(rd_data_out), .rd_data_valid(rd_data_valid),
  .rd_data_empty(rd_data_empty), .mem_rd_n(mem_rd_n), .mem_clk_k(mem_clk_k),
  .mem_q_valid(mem_q_valid), .input_clk_source_sel(input_clk_source_sel),
  .output_clk_derive_sel(output_clk_derive_sel), .pll_n(pll_n), .pll_m(pll_m));

// *** testbench/qdrmc_sram_model.sv ***
// Behavioural burst SRAM on the read port, two or four words per read.
// Assumes one returned word per clk_sys cycle; slow adds delay and gaps.
`timescale 1ns/10ps

module qdrmc_sram_model (
  input  wire        clk_sys,
  input  wire        mem_rd_n,
  input  wire [17:0] mem_addr,
  input  wire        slow,
  input  wire        burst4,
  output reg  [35:0] mem_q,
  output reg         mem_q_valid
);
  logic [35:0] words[$];
  int          due[$];
  int          cyc;

  // Quiet bus at start
  initial begin
    mem_q       = 36'h000000000;
    mem_q_valid = 1'b0;
    cyc         = 0;
  end

  // Queue two words per read (four with burst4), return them after the access delay
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (mem_rd_n == 1'b0) begin
      // Word index in the burst tags the top two bits
      for (int j = 0; j < (burst4 ? 4 : 2); j++) begin
        words.push_back({j[0], j[1], 16'h0000, mem_addr});
        due.push_back(slow ? cyc + 9 : cyc + 2);
      end
    end
    if (words.size() > 0 && cyc >= due[0] && !(slow && cyc[0])) begin
      mem_q       <= words.pop_front();
      mem_q_valid <= 1'b1;
      void'(due.pop_front());
    end else begin
      mem_q       <= ~mem_q; // Released bus toggles, so the last word shows every other cycle
      mem_q_valid <= 1'b0;
    end
  end
endmodule // qdrmc_sram_model

// *** testbench/testbench.sv ***
// Self-checking bench for the read controller with the SRAM model.
// Assumes fabric and core share one 20 MHz clock.
`timescale 1ns/10ps
`include "qdrmc_regs.vh"

module testbench;
  logic        clk_sys, rst_n, ce, reg_wr, reg_rd, fabric_instr_wr, fabric_rd_pop, slow;
  logic        rd_instr_queue_full, rd_data_valid, rd_data_empty, mem_rd_n, mem_clk_k;
  logic        mem_q_valid, output_clk_derive_sel, ck, burst;
  logic [19:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rv, pf, d;
  logic [31:0] fabric_instr_data;
  logic [71:0] rd_data_out;
  logic [71:0] exp_q[$];
  logic [3:0]  evt;
  logic [17:0] mem_addr;
  logic [35:0] mem_q;
  logic [1:0]  input_clk_source_sel;
  logic [2:0]  pll_n, pll_m;
  int          errors, comparisons, i, n;

  qdrmc_read_ctrl qdrmc_read_ctrl_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .fabric_instr_wr(fabric_instr_wr),
    .fabric_instr_data(fabric_instr_data), .rd_instr_queue_full(rd_instr_queue_full),
    .fabric_rd_pop(fabric_rd_pop), .rd_data_out(rd_data_out), .rd_data_valid(rd_data_valid),
    .rd_data_empty(rd_data_empty), .wr_len_mismatch_evt(evt[0]), .wr_id_mismatch_evt(evt[1]),
    .wr_buf_overrun_evt(evt[2]), .wr_buf_underrun_evt(evt[3]), .mem_addr(mem_addr),
    .mem_rd_n(mem_rd_n), .mem_clk_k(mem_clk_k), .mem_q(mem_q), .mem_q_valid(mem_q_valid),
    .input_clk_source_sel(input_clk_source_sel), .output_clk_derive_sel(output_clk_derive_sel),
    .pll_n(pll_n), .pll_m(pll_m));
  qdrmc_sram_model qdrmc_sram_model_inst (.clk_sys(clk_sys), .mem_rd_n(mem_rd_n),
    .mem_addr(mem_addr), .slow(slow), .burst4(burst), .mem_q(mem_q),
    .mem_q_valid(mem_q_valid));

  ////////////////////////////////////////////////////////////////////////////
  // Compare, verdict and expected line
  task check(input string name, input logic [71:0] expv, input logic [71:0] got);
    comparisons++;
    if (got !== expv) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, expv, got);
    end
  endtask
  task summarize();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Line k of an instruction; 4-word bursts give two lines per address
  function logic [71:0] line_of(input logic [17:0] ad, input int k);
    logic [17:0] a;
    logic        hi;
    a  = burst ? ad + 18'(k / 2) : ad + 18'(k);
    hi = burst & k[0];
    return {1'b0, hi, 16'h0000, a, 1'b1, hi, 16'h0000, a};
  endfunction

  // Register and fabric bus cycles
  task reg_write(input logic [19:0] ad, input logic [7:0] wd);
    @(posedge clk_sys);
    reg_addr  <= ad;
    reg_wdata <= wd;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task reg_read(input logic [19:0] ad, output logic [7:0] rd);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  task push(input logic [17:0] ad, input logic [7:0] len);
    @(posedge clk_sys);
    fabric_instr_data <= {6'h00, len, ad};
    fabric_instr_wr   <= 1'b1;
    @(posedge clk_sys);
    fabric_instr_wr <= 1'b0;
    for (int k = 0; k < len; k++) exp_q.push_back(line_of(ad, k));
  endtask
  task pop_lines(input int cnt);
    int w;
    #1;
    repeat (cnt) begin
      w = 0;
      while (rd_data_empty !== 1'b0 && w < 400) begin
        @(posedge clk_sys);
        #1 w++;
      end
      check("empty flag", 72'h0, {71'h0, rd_data_empty});
      @(posedge clk_sys);
      fabric_rd_pop <= 1'b1;
      @(posedge clk_sys);
      fabric_rd_pop <= 1'b0;
      #1 check("read valid", 72'h1, {71'h0, rd_data_valid});
      check("read line", exp_q.pop_front(), rd_data_out);
      @(posedge clk_sys);
      #1;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    #(50 * 20000);
    errors++;
    summarize();
  end

  // Main sequence
  initial begin
    {rst_n, reg_wr, reg_rd, fabric_instr_wr, fabric_rd_pop, slow, burst, evt} = 11'h000;
    {reg_addr, reg_wdata, fabric_instr_data} = 60'h0;
    ce = 1'b1;
    errors = 0;
    comparisons = 0;
    void'($urandom(44));
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1 check("reset flags", 72'h5, {rd_data_empty, rd_instr_queue_full, mem_rd_n});
    for (i = 0; i < 4; i++) begin
      ck = 1'($urandom);
      rv = {2'b00, i[1:0], 3'b000, ck};
      pf = {1'b0, 3'($urandom), 1'b0, 3'($urandom)};
      reg_write(`QDRMC_CLOCK_CONFIG, rv);
      reg_write(`QDRMC_PLL_FACTORS, pf);
      repeat (2) @(posedge clk_sys);
      #1 check("clock ctrl", {i[1:0], ck, pf[6:4], pf[2:0]},
        {input_clk_source_sel, output_clk_derive_sel, pll_n, pll_m});
      reg_read(`QDRMC_CLOCK_CONFIG, d);
      check("config readback", rv, d);
      reg_read(`QDRMC_PLL_FACTORS, d);
      check("pll readback", pf, d);
    end
    reg_write(20'h30a03, 8'hff);
    reg_read(`QDRMC_CLOCK_CONFIG, d);
    check("config after foreign write", rv, d);
    reg_read(20'h30b07, d);
    check("unmapped read", 72'h0, d);
    reg_read(20'h30a03, d);
    check("foreign read", 72'h0, d);
    @(posedge clk_sys);
    ce <= 1'b0;
    @(posedge clk_sys);
    #1 ck = mem_clk_k;
    repeat (3) @(posedge clk_sys);
    #1 check("clock held", ck, mem_clk_k);
    @(posedge clk_sys);
    ce <= 1'b1;
    for (i = 0; i < 6; i++) begin
      #1;
      while (rd_instr_queue_full === 1'b1) begin
        @(posedge clk_sys);
        #1;
      end
      push(18'($urandom), 8'($urandom_range(4, 1)));
    end
    pop_lines(exp_q.size());
    reg_write(`QDRMC_EMPTY_LEVEL, 8'h02);
    push(18'h00100, 8'h02);
    repeat (40) @(posedge clk_sys);
    #1 check("empty at level", 72'h1, {71'h0, rd_data_empty});
    push(18'h00200, 8'h01);
    repeat (40) @(posedge clk_sys);
    #1 check("empty above level", 72'h0, {71'h0, rd_data_empty});
    reg_write(`QDRMC_EMPTY_LEVEL, 8'h00);
    pop_lines(3);
    // Four-word bursts: two lines per read address
    burst <= 1'b1;
    reg_write(`QDRMC_CLOCK_CONFIG, {1'b1, rv[6:0]});
    push(18'h00300, 8'h04);
    pop_lines(4);
    burst <= 1'b0;
    reg_write(`QDRMC_CLOCK_CONFIG, rv);
    slow <= 1'b1;
    push(18'h01000, 8'h40);
    repeat (400) @(posedge clk_sys);
    for (i = 0; i < 3; i++) push(18'h02000 + 18'(i), 8'h01);
    repeat (2) @(posedge clk_sys);
    #1 check("queue below full", 72'h0, {71'h0, rd_instr_queue_full});
    push(18'h02003, 8'h01);
    repeat (2) @(posedge clk_sys);
    #1 check("queue full", 72'h1, {71'h0, rd_instr_queue_full});
    push(18'h02004, 8'h01);
    pop_lines(69);
    slow <= 1'b0;
    @(posedge clk_sys);
    fabric_rd_pop <= 1'b1;
    @(posedge clk_sys);
    fabric_rd_pop <= 1'b0;
    #1 check("valid on empty pop", 72'h0, {71'h0, rd_data_valid});
    for (i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      evt <= 4'(1 << i);
      @(posedge clk_sys);
      evt <= 4'h0;
    end
    reg_read(`QDRMC_ALARM_STATUS, d);
    check("alarms", 8'h2f, d);
    repeat (10) @(posedge clk_sys);
    reg_read(`QDRMC_ALARM_STATUS, d);
    check("alarms kept", 8'h2f, d);
    reg_write(`QDRMC_ALARM_STATUS, 8'h0f);
    reg_read(`QDRMC_ALARM_STATUS, d);
    check("alarms part cleared", 8'h20, d);
    summarize();
  end
endmodule // testbench
